// *** common/lpmc_pkg.sv ***
// Constants, register map and state codes of the low power mode controller.
`default_nettype none
package lpmc_pkg;
  // ==========================================================================
  // Timing
  localparam int CLK_PERIOD_NS = 5;
  localparam int ENTRY_NS      = 10;
  localparam int PWRCUT_NS     = 20;
  localparam int DRST_NS       = 1000;
  localparam int ENTRY_CYC     = (ENTRY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PWRCUT_CYC    = (PWRCUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DRST_CYC      = (DRST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W         = 16;
  // ==========================================================================
  // Register offsets
  localparam logic [7:0] OFS_STANDBY_CONTROL = 8'h00;
  localparam logic [7:0] OFS_CLK_SEL         = 8'h04;
  localparam logic [7:0] OFS_LINK_SEL        = 8'h08;
  localparam logic [7:0] OFS_SNZ_WAKE        = 8'h0C;
  localparam logic [7:0] OFS_RESET_STATUS0   = 8'h10;
  localparam logic [7:0] OFS_IRQ_STAT        = 8'h14;
  localparam logic [7:0] OFS_IRQ_MASK        = 8'h18;
  localparam logic [7:0] OFS_STATE           = 8'h1C;
  // ==========================================================================
  // Fields and reset values
  localparam int         SBY_W      = 3;
  localparam int         SNZ_EN_BIT = 2;
  localparam logic [1:0] MODE_HALT  = 2'h0;
  localparam logic [1:0] MODE_STBY  = 2'h1;
  localparam logic [1:0] MODE_DEEP  = 2'h2;
  localparam logic [2:0] SBY_RST    = 3'h0;
  localparam logic [2:0] CLK_MOSC   = 3'h0;
  localparam logic [2:0] CLK_HOCO   = 3'h1;
  localparam logic [2:0] CLK_MEDIUM_SPEED_INTERNAL_OSC   = 3'h2;
  localparam logic [2:0] CLK_LOCO   = 3'h3;
  localparam logic [2:0] CLK_SOSC   = 3'h4;
  localparam int         EV_W       = 3;
  localparam int         EV_WAKE    = 0;
  localparam int         EV_CANCEL  = 1;
  localparam int         EV_DEEPX   = 2;
  localparam int         DPS_FLAG   = 0;
  // ==========================================================================
  // Controller states
  typedef enum logic [7:0] {
    ST_NORMAL = 8'h01,
    ST_ENTRY  = 8'h02,
    ST_HALT   = 8'h04,
    ST_STBY   = 8'h08,
    ST_SNZ    = 8'h10,
    ST_PWRCUT = 8'h20,
    ST_DEEP   = 8'h40,
    ST_DRST   = 8'h80
  } lpmc_state_type;
endpackage
`default_nettype wire

// *** src/lpmc_top.sv ***
// Low power mode sequencer with its AHB-Lite register slave.
//
// Functional notes
// - Cancel interrupt during entry takes exception.
// - Reset exit selects medium-speed oscillator.
// - Halt, standby or snooze wake restores clock source used before.
// - Deep wake: hold internal reset, then reset.
// - Halt stops CPU, peripherals keep running.
// - Any linked interrupt or reset ends halt.
// - Standby stops CPU, peripherals, oscillators; retains.
// - Snooze only from standby on request.
// - Snooze ends only on snooze-capable interrupts or resets.
// - Cut internal supply before deep standby.
// - After deep standby, context is lost.
// - Pin, power-on, monitor resets end states.
// - Deep standby reset sets status flag.
// - Snooze by request; others by WFI.
//
// Decided for this implementation: the register addresses and the AHB-Lite register port.
`timescale 1ns/10ps
`default_nettype none
module lpmc_top
  import lpmc_pkg::*;
#(
  parameter int N_IRQ    = 8,
  parameter int DRST_CNT = DRST_CYC
) (
  input  wire logic             hclk,                 // Clock.
  input  wire logic             hresetn,              // Async reset.
  input  wire logic             hsel,                 // Slave select.
  input  wire logic [31:0]      haddr,                // Address.
  input  wire logic [1:0]       htrans,               // Transfer type.
  input  wire logic             hwrite,               // Write.
  input  wire logic [2:0]       hsize,                // Size, words only.
  input  wire logic [31:0]      hwdata,               // Write data.
  input  wire logic             hready,               // Bus ready.
  output logic [31:0]           hrdata,               // Read data.
  output logic                  hreadyout,            // Slave ready.
  output logic                  hresp,                // Response.
  input  wire logic             wfi_i,                // WFI executed.
  input  wire logic [N_IRQ-1:0] irq_in,               // Interrupts.
  input  wire logic             snooze_req_i,         // Snooze request.
  input  wire logic             external_reset_pin_n, // Reset pin.
  input  wire logic             por_req_i,            // Power-on reset.
  input  wire logic             lvd_req_i,            // Monitor reset.
  output logic                  cpu_halt_o,           // CPU stopped.
  output logic                  periph_stop_o,        // Peripherals off.
  output logic                  osc_stop_o,           // Oscillators off.
  output logic                  supply_cut_o,         // Supply cut.
  output logic                  deep_rst_o,           // Deep reset.
  output logic                  snooze_o,             // Snooze active.
  output logic                  ctx_valid_o,          // Context kept.
  output logic                  exc_take_o,           // Take interrupt.
  output logic                  reset_exc_o,          // Reset exception.
  output logic [2:0]            clk_src_o,            // Clock source.
  output logic [7:0]            low_power_state_o,    // State.
  output logic                  irq_o                 // Interrupt.
);
  // ==========================================================================
  // Declarations
  lpmc_state_type       state_r, state_nxt, tgt_r, tgt_nxt;
  logic [CNT_W-1:0]     cnt_r, cnt_nxt;
  logic [2:0]           saved_clk_r, saved_clk_nxt;
  logic [7:0]           flags_r, flags_nxt;
  logic                 exc_r, exc_nxt, rexc_r, rexc_nxt;
  logic [EV_W-1:0]      ev;
  logic                 to_medium_speed_internal_osc, restore, drst_done;
  logic                 ap_v_r, ap_v_nxt, ap_w_r, ap_w_nxt;
  logic [7:0]           ap_a_r, ap_a_nxt;
  logic [31:0]          hrdata_r, hrdata_nxt;
  logic                 hready_r, hresp_r, irq_r, irq_nxt;
  logic [SBY_W-1:0]     sby_r, sby_nxt;
  logic [2:0]           clk_sel_r, clk_sel_nxt;
  logic [N_IRQ-1:0]     link_r, link_nxt, snz_ok_r, snz_ok_nxt;
  logic [EV_W-1:0]      stat_r, stat_nxt, mask_r, mask_nxt;
  logic                 dps_r, dps_nxt;
  logic                 rst_req, sel, wr;
  logic [N_IRQ-1:0]     wake_src;

  assign rst_req  = !external_reset_pin_n || por_req_i || lvd_req_i;
  assign wake_src = irq_in & link_r;
  assign sel      = hsel && htrans[1] && hready;
  assign wr       = ap_v_r && ap_w_r;

  // ==========================================================================
  // Mode sequencer
  always_comb begin
    state_nxt     = state_r;
    tgt_nxt       = tgt_r;
    cnt_nxt       = cnt_r;
    saved_clk_nxt = saved_clk_r;
    exc_nxt       = 1'b0;
    rexc_nxt      = 1'b0;
    ev            = '0;
    to_medium_speed_internal_osc       = 1'b0;
    restore       = 1'b0;
    drst_done     = 1'b0;
    if (rst_req) begin
      state_nxt = ST_NORMAL;
      rexc_nxt  = 1'b1;
      to_medium_speed_internal_osc   = 1'b1;
    end else begin
      unique case (state_r)
        ST_NORMAL: if (wfi_i) begin
          state_nxt     = ST_ENTRY;
          cnt_nxt       = CNT_W'(ENTRY_CYC - 1);
          saved_clk_nxt = clk_sel_r;
          if (sby_r[1:0] == MODE_STBY) tgt_nxt = ST_STBY;
          else if (sby_r[1:0] == MODE_DEEP) tgt_nxt = ST_PWRCUT;
          else tgt_nxt = ST_HALT;
        end
        ST_ENTRY: begin
          if (|wake_src) begin
            state_nxt      = ST_NORMAL;
            exc_nxt        = 1'b1;
            ev[EV_CANCEL]  = 1'b1;
          end else if (cnt_r == '0) begin
            state_nxt = tgt_r;
            cnt_nxt   = CNT_W'(PWRCUT_CYC - 1);
          end else begin
            cnt_nxt = cnt_r - 1'b1;
          end
        end
        ST_HALT, ST_STBY: begin
          if (|wake_src) begin
            state_nxt    = ST_NORMAL;
            restore      = 1'b1;
            exc_nxt      = 1'b1;
            ev[EV_WAKE]  = 1'b1;
          end else if (state_r == ST_STBY && snooze_req_i && sby_r[SNZ_EN_BIT]) begin
            state_nxt = ST_SNZ;
          end
        end
        ST_SNZ: if (|(irq_in & snz_ok_r)) begin
          state_nxt   = ST_NORMAL;
          restore     = 1'b1;
          exc_nxt     = 1'b1;
          ev[EV_WAKE] = 1'b1;
        end
        ST_PWRCUT: begin
          if (cnt_r == '0) state_nxt = ST_DEEP;
          else cnt_nxt = cnt_r - 1'b1;
        end
        ST_DEEP: if (|wake_src) begin
          state_nxt = ST_DRST;
          cnt_nxt   = CNT_W'(DRST_CNT - 1);
        end
        ST_DRST: begin
          if (cnt_r == '0) begin
            state_nxt     = ST_NORMAL;
            rexc_nxt      = 1'b1;
            to_medium_speed_internal_osc       = 1'b1;
            drst_done     = 1'b1;
            ev[EV_DEEPX]  = 1'b1;
          end else begin
            cnt_nxt = cnt_r - 1'b1;
          end
        end
      endcase
    end
    // Power controls follow the state being entered so they are plain flops.
    flags_nxt[0] = state_nxt != ST_NORMAL;
    flags_nxt[1] = state_nxt inside {ST_STBY, ST_SNZ, ST_PWRCUT, ST_DEEP, ST_DRST};
    flags_nxt[2] = state_nxt inside {ST_STBY, ST_PWRCUT, ST_DEEP};
    flags_nxt[3] = state_nxt inside {ST_PWRCUT, ST_DEEP};
    flags_nxt[4] = state_nxt == ST_DRST;
    flags_nxt[5] = state_nxt == ST_SNZ;
    flags_nxt[6] = !(state_nxt inside {ST_DEEP, ST_DRST});
    flags_nxt[7] = 1'b0;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_r     <= ST_NORMAL;
      tgt_r       <= ST_HALT;
      cnt_r       <= '0;
      saved_clk_r <= CLK_MEDIUM_SPEED_INTERNAL_OSC;
      flags_r     <= 8'h40;
      exc_r       <= 1'b0;
      rexc_r      <= 1'b0;
    end else begin
      state_r     <= state_nxt;
      tgt_r       <= tgt_nxt;
      cnt_r       <= cnt_nxt;
      saved_clk_r <= saved_clk_nxt;
      flags_r     <= flags_nxt;
      exc_r       <= exc_nxt;
      rexc_r      <= rexc_nxt;
    end
  end

  // ==========================================================================
  // Register slave
  function automatic logic [31:0] rd_mux(input logic [7:0] a);
    rd_mux = 32'h0;
    case (a)
      OFS_STANDBY_CONTROL: rd_mux[SBY_W-1:0] = sby_r;
      OFS_CLK_SEL:         rd_mux[2:0] = clk_sel_r;
      OFS_LINK_SEL:        rd_mux[N_IRQ-1:0] = link_r;
      OFS_SNZ_WAKE:        rd_mux[N_IRQ-1:0] = snz_ok_r;
      OFS_RESET_STATUS0:   rd_mux[DPS_FLAG] = dps_r;
      OFS_IRQ_STAT:        rd_mux[EV_W-1:0] = stat_r;
      OFS_IRQ_MASK:        rd_mux[EV_W-1:0] = mask_r;
      OFS_STATE:           rd_mux[7:0] = state_r;
      default:             rd_mux = 32'h0;
    endcase
  endfunction

  always_comb begin
    ap_v_nxt    = sel;
    ap_w_nxt    = hwrite;
    ap_a_nxt    = haddr[7:0];
    hrdata_nxt  = (sel && !hwrite) ? rd_mux(haddr[7:0]) : hrdata_r;
    sby_nxt     = sby_r;
    clk_sel_nxt = clk_sel_r;
    link_nxt    = link_r;
    snz_ok_nxt  = snz_ok_r;
    mask_nxt    = mask_r;
    stat_nxt    = stat_r;
    dps_nxt     = dps_r;
    if (wr) begin
      case (ap_a_r)
        OFS_STANDBY_CONTROL: sby_nxt = hwdata[SBY_W-1:0];
        OFS_CLK_SEL:         clk_sel_nxt = hwdata[2:0];
        OFS_LINK_SEL:        link_nxt = hwdata[N_IRQ-1:0];
        OFS_SNZ_WAKE:        snz_ok_nxt = hwdata[N_IRQ-1:0];
        OFS_IRQ_MASK:        mask_nxt = hwdata[EV_W-1:0];
        OFS_IRQ_STAT:        stat_nxt = stat_r & ~hwdata[EV_W-1:0];
        OFS_RESET_STATUS0:   dps_nxt = dps_r & ~hwdata[DPS_FLAG];
        default:             ;
      endcase
    end
    // Hardware sets win over a write-one clear in the same cycle.
    stat_nxt = stat_nxt | ev;
    if (restore) clk_sel_nxt = saved_clk_r;
    if (to_medium_speed_internal_osc) clk_sel_nxt = CLK_MEDIUM_SPEED_INTERNAL_OSC;
    if (drst_done) begin
      sby_nxt    = SBY_RST;
      link_nxt   = '0;
      snz_ok_nxt = '0;
      mask_nxt   = '0;
      dps_nxt    = 1'b1;
    end
    irq_nxt = |(stat_nxt & mask_nxt);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_v_r    <= 1'b0;
      ap_w_r    <= 1'b0;
      ap_a_r    <= 8'h00;
      hrdata_r  <= 32'h0;
      hready_r  <= 1'b1;
      hresp_r   <= 1'b0;
      sby_r     <= SBY_RST;
      clk_sel_r <= CLK_MEDIUM_SPEED_INTERNAL_OSC;
      link_r    <= '0;
      snz_ok_r  <= '0;
      mask_r    <= '0;
      stat_r    <= '0;
      dps_r     <= 1'b0;
      irq_r     <= 1'b0;
    end else begin
      ap_v_r    <= ap_v_nxt;
      ap_w_r    <= ap_w_nxt;
      ap_a_r    <= ap_a_nxt;
      hrdata_r  <= hrdata_nxt;
      hready_r  <= 1'b1;
      hresp_r   <= 1'b0;
      sby_r     <= sby_nxt;
      clk_sel_r <= clk_sel_nxt;
      link_r    <= link_nxt;
      snz_ok_r  <= snz_ok_nxt;
      mask_r    <= mask_nxt;
      stat_r    <= stat_nxt;
      dps_r     <= dps_nxt;
      irq_r     <= irq_nxt;
    end
  end

  assign hrdata            = hrdata_r;
  assign hreadyout         = hready_r;
  assign hresp             = hresp_r;
  assign cpu_halt_o        = flags_r[0];
  assign periph_stop_o     = flags_r[1];
  assign osc_stop_o        = flags_r[2];
  assign supply_cut_o      = flags_r[3];
  assign deep_rst_o        = flags_r[4];
  assign snooze_o          = flags_r[5];
  assign ctx_valid_o       = flags_r[6];
  assign exc_take_o        = exc_r;
  assign reset_exc_o       = rexc_r;
  assign clk_src_o         = clk_sel_r;
  assign low_power_state_o = state_r;
  assign irq_o             = irq_r;

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_deep_wake;
    state_r == ST_DEEP && |wake_src && !rst_req;
  endsequence
  sequence s_drst_hold;
    deep_rst_o [*8] ##[1:300] reset_exc_o;
  endsequence

  property p_cancel;
    state_r == ST_ENTRY && |wake_src && !rst_req |=> exc_take_o && state_r == ST_NORMAL;
  endproperty
  a_cancel: assert property (p_cancel) else $error("entry not cancelled");
  property p_medium_speed_internal_osc;
    reset_exc_o |-> clk_src_o == CLK_MEDIUM_SPEED_INTERNAL_OSC;
  endproperty
  a_medium_speed_internal_osc: assert property (p_medium_speed_internal_osc) else $error("reset exit not on medium_speed_internal_osc");
  property p_restore;
    state_r == ST_NORMAL && $past(state_r) inside {ST_HALT, ST_STBY, ST_SNZ}
      && !$past(rst_req) |-> clk_src_o == saved_clk_r;
  endproperty
  a_restore: assert property (p_restore) else $error("clock not restored");
  property p_drst;
    s_deep_wake |=> s_drst_hold;
  endproperty
  a_drst: assert property (p_drst) else $error("deep reset sequence wrong");
  property p_halt;
    state_r == ST_HALT |-> cpu_halt_o && !periph_stop_o && ctx_valid_o;
  endproperty
  a_halt: assert property (p_halt) else $error("halt outputs wrong");
  property p_stby;
    state_r == ST_STBY |-> cpu_halt_o && periph_stop_o && osc_stop_o && ctx_valid_o;
  endproperty
  a_stby: assert property (p_stby) else $error("standby outputs wrong");
  property p_snz_in;
    state_r == ST_SNZ && $past(state_r) != ST_SNZ |-> $past(state_r) == ST_STBY;
  endproperty
  a_snz_in: assert property (p_snz_in) else $error("snooze not from standby");
  property p_snz_out;
    state_r == ST_SNZ && !(|(irq_in & snz_ok_r)) && !rst_req |=> state_r == ST_SNZ;
  endproperty
  a_snz_out: assert property (p_snz_out) else $error("snooze left wrongly");
  property p_cut;
    state_r == ST_DEEP && $past(state_r) == ST_PWRCUT |-> $past(supply_cut_o, 2);
  endproperty
  a_cut: assert property (p_cut) else $error("supply not cut first");
  property p_flag;
    $fell(deep_rst_o) && !$past(rst_req) |-> dps_r && reset_exc_o;
  endproperty
  a_flag: assert property (p_flag) else $error("deep reset flag not set");
  property p_wfi;
    state_r == ST_NORMAL && wfi_i && !rst_req |=> state_r == ST_ENTRY
      && tgt_r inside {ST_HALT, ST_STBY, ST_PWRCUT};
  endproperty
  a_wfi: assert property (p_wfi) else $error("wfi not committed");
endmodule // lpmc_top
`default_nettype wire

// *** dv/lpmc_cpu_model.sv ***
// Behavioural CPU core and interrupt sources facing the power sequencer.
`timescale 1ns/10ps
`default_nettype none
module lpmc_cpu_model #(
  parameter int N_IRQ = 8
) (
  input  wire logic             hclk,         // Clock.
  input  wire logic             exc_take_o,   // Exception taken.
  input  wire logic             reset_exc_o,  // Reset exception run.
  output var  logic             wfi_i,        // WFI executed.
  output var  logic [N_IRQ-1:0] irq_in,       // Interrupt levels.
  output var  logic             snooze_req_i  // Snooze request.
);
  initial begin
    wfi_i = 1'b0;
    irq_in = '0;
    snooze_req_i = 1'b0;
  end
  // A source holds its request until the core acknowledges it, as real peripherals do.
  always @(posedge hclk) begin
    if (exc_take_o === 1'b1 || reset_exc_o === 1'b1) begin
      irq_in <= '0;
    end
  end
  // The cancel mask lets a source fire while the entry sequence is still running.
  task automatic wfi_pulse(input logic [N_IRQ-1:0] cancel);
    @(posedge hclk);
    wfi_i <= 1'b1;
    @(posedge hclk);
    wfi_i <= 1'b0;
    irq_in <= irq_in | cancel;
  endtask
  task automatic raise(input int idx);
    @(posedge hclk);
    irq_in[idx] <= 1'b1;
  endtask
  task automatic snooze(input logic on);
    @(posedge hclk);
    snooze_req_i <= on;
  endtask
endmodule // lpmc_cpu_model
`default_nettype wire

// *** dv/lpmc_top_tb_top.sv ***
// Self-checking testbench of the low power mode sequencer.
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin err_total++; \
  $display("[ERR] %0t got %0h exp %0h", $time, (a), (b)); end end
`define WAITF(c) begin #1; wn = 0; while ((c) !== 1'b1 && wn < 500) begin \
  @(posedge hclk); #1; wn++; end if (wn >= 500) begin err_total++; end_of_test(); end end
module lpmc_top_tb_top;
  import lpmc_pkg::*;
  localparam int DRST_N = 10;
  logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, wfi_i, snooze_req_i;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans;
  logic [2:0]  hsize, clk_src_o;
  logic [7:0]  irq_in, low_power_state_o;
  logic        pin_n, por, lvd, cpu_halt_o, periph_stop_o, osc_stop_o, supply_cut_o;
  logic        deep_rst_o, snooze_o, ctx_valid_o, exc_take_o, reset_exc_o, irq_o;
  int          err_total, compares, wn, cnt;
  logic [23:0] apage;
  logic        sel_q;
  logic [1:0]  tr_q;
  assign hready = hreadyout;
  lpmc_top #(.N_IRQ(8), .DRST_CNT(DRST_N)) dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .wfi_i(wfi_i), .irq_in(irq_in),
    .snooze_req_i(snooze_req_i), .external_reset_pin_n(pin_n), .por_req_i(por),
    .lvd_req_i(lvd), .cpu_halt_o(cpu_halt_o), .periph_stop_o(periph_stop_o),
    .osc_stop_o(osc_stop_o), .supply_cut_o(supply_cut_o), .deep_rst_o(deep_rst_o),
    .snooze_o(snooze_o), .ctx_valid_o(ctx_valid_o), .exc_take_o(exc_take_o),
    .reset_exc_o(reset_exc_o), .clk_src_o(clk_src_o), .low_power_state_o(low_power_state_o),
    .irq_o(irq_o));
  lpmc_cpu_model #(.N_IRQ(8)) u_cpu (
    .hclk(hclk), .exc_take_o(exc_take_o), .reset_exc_o(reset_exc_o), .wfi_i(wfi_i),
    .irq_in(irq_in), .snooze_req_i(snooze_req_i));
  // ==========================================================================
  // Bus and closing tasks
  task automatic end_of_test();
    if (err_total == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge hclk);
    hsel <= sel_q;
    htrans <= tr_q;
    hwrite <= w;
    haddr <= {apage, a};
    do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 50);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 50);
    rd = hrdata;
    if (n >= 50) begin
      err_total++;
      end_of_test();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] x;
    bus(1'b0, a, 32'h0, x);
    `CHK(x, e)
    `CHK(hresp, 1'b0)
  endtask
  // ==========================================================================
  // Scenarios
  task automatic t_reset();
    `CHK(clk_src_o, CLK_MEDIUM_SPEED_INTERNAL_OSC)
    `CHK(low_power_state_o, ST_NORMAL)
    rdc(OFS_CLK_SEL, 32'h2);
    rdc(8'h20, 32'h0);
  endtask
  task automatic t_halt();
    wr(OFS_CLK_SEL, 32'h1);
    wr(OFS_LINK_SEL, 32'h1);
    wr(OFS_IRQ_MASK, 32'h7);
    wr(OFS_STANDBY_CONTROL, {30'h0, MODE_HALT});
    u_cpu.wfi_pulse(8'h0);
    `WAITF(low_power_state_o == ST_HALT)
    `CHK({cpu_halt_o, periph_stop_o, osc_stop_o, ctx_valid_o}, 4'h9)
    u_cpu.raise(1);
    repeat (5) @(posedge hclk);
    #1;
    `CHK(low_power_state_o, ST_HALT)
    u_cpu.raise(0);
    `WAITF(exc_take_o)
    `CHK(low_power_state_o, ST_NORMAL)
    `CHK(clk_src_o, CLK_HOCO)
    rdc(OFS_IRQ_STAT, 32'h1);
    `CHK(irq_o, 1'b1)
    wr(OFS_IRQ_STAT, 32'h1);
    rdc(OFS_IRQ_STAT, 32'h0);
    `CHK(irq_o, 1'b0)
  endtask
  task automatic t_cancel();
    wr(OFS_STANDBY_CONTROL, {30'h0, MODE_STBY});
    u_cpu.wfi_pulse(8'h1);
    `WAITF(exc_take_o)
    `CHK(low_power_state_o, ST_NORMAL)
    rdc(OFS_IRQ_STAT, 32'h2);
    wr(OFS_IRQ_STAT, 32'h2);
  endtask
  task automatic t_snooze();
    wr(OFS_STANDBY_CONTROL, 32'h5);
    wr(OFS_SNZ_WAKE, 32'h2);
    u_cpu.wfi_pulse(8'h0);
    `WAITF(low_power_state_o == ST_STBY)
    `CHK({periph_stop_o, osc_stop_o, ctx_valid_o, snooze_o}, 4'hE)
    u_cpu.snooze(1'b1);
    `WAITF(low_power_state_o == ST_SNZ)
    `CHK({snooze_o, osc_stop_o, cpu_halt_o}, 3'h5)
    u_cpu.raise(0);
    repeat (5) @(posedge hclk);
    #1;
    `CHK(low_power_state_o, ST_SNZ)
    u_cpu.raise(1);
    `WAITF(exc_take_o)
    `CHK(low_power_state_o, ST_NORMAL)
    u_cpu.snooze(1'b0);
    wr(OFS_IRQ_STAT, 32'h7);
  endtask
  task automatic t_deep();
    wr(OFS_CLK_SEL, 32'h3);
    wr(OFS_STANDBY_CONTROL, {30'h0, MODE_DEEP});
    u_cpu.wfi_pulse(8'h0);
    `WAITF(low_power_state_o == ST_PWRCUT)
    `CHK({supply_cut_o, periph_stop_o, cpu_halt_o}, 3'h7)
    cnt = 0;
    while (low_power_state_o === ST_PWRCUT && cnt < 500) begin @(posedge hclk); #1; cnt++; end
    `CHK(cnt, PWRCUT_CYC)
    `CHK({ctx_valid_o, supply_cut_o, low_power_state_o}, {2'h1, ST_DEEP})
    u_cpu.raise(0);
    `WAITF(deep_rst_o)
    cnt = 0;
    while (deep_rst_o === 1'b1 && cnt < 500) begin @(posedge hclk); #1; cnt++; end
    `CHK(cnt, DRST_N)
    `WAITF(reset_exc_o)
    `CHK({low_power_state_o, clk_src_o}, {ST_NORMAL, CLK_MEDIUM_SPEED_INTERNAL_OSC})
    rdc(OFS_RESET_STATUS0, 32'h1);
    rdc(OFS_IRQ_STAT, 32'h4);
    `CHK(irq_o, 1'b0)
    rdc(OFS_LINK_SEL, 32'h0);
    wr(OFS_RESET_STATUS0, 32'h1);
    rdc(OFS_RESET_STATUS0, 32'h0);
    wr(OFS_IRQ_STAT, 32'h4);
  endtask
  task automatic t_resets();
    for (int k = 0; k < 3; k++) begin
      wr(OFS_CLK_SEL, 32'h1);
      wr(OFS_STANDBY_CONTROL, 32'h3);
      u_cpu.wfi_pulse(8'h0);
      `WAITF(low_power_state_o == ST_HALT)
      `CHK(cpu_halt_o, 1'b1)
      @(posedge hclk);
      pin_n <= (k != 0);
      por <= (k == 1);
      lvd <= (k == 2);
      @(posedge hclk);
      pin_n <= 1'b1;
      por <= 1'b0;
      lvd <= 1'b0;
      `WAITF(reset_exc_o)
      `CHK({low_power_state_o, clk_src_o}, {ST_NORMAL, CLK_MEDIUM_SPEED_INTERNAL_OSC})
    end
    rdc(OFS_RESET_STATUS0, 32'h0);
  endtask
  // Upper address bits are ignored; a deselected slave or a BUSY transfer must not write.
  task automatic t_bus();
    apage = 24'hA5A5A5;
    wr(OFS_CLK_SEL, 32'h4);
    apage = 24'h0;
    rdc(OFS_CLK_SEL, 32'h4);
    sel_q = 1'b0;
    wr(OFS_CLK_SEL, 32'h1);
    sel_q = 1'b1;
    tr_q = 2'h1;
    wr(OFS_CLK_SEL, 32'h1);
    tr_q = 2'h3;
    rdc(OFS_CLK_SEL, 32'h4);
    wr(OFS_CLK_SEL, 32'h0);
    tr_q = 2'h2;
    rdc(OFS_CLK_SEL, 32'h0);
  endtask
  // A bus reset in mid-run must drop standby and bring the standby control and clock select registers back to their reset values.
  task automatic t_hreset();
    wr(OFS_CLK_SEL, 32'h1);
    wr(OFS_STANDBY_CONTROL, {30'h0, MODE_STBY});
    u_cpu.wfi_pulse(8'h0);
    `WAITF(low_power_state_o == ST_STBY)
    @(posedge hclk);
    hresetn <= 1'b0;
    @(posedge hclk);
    hresetn <= 1'b1;
    #1;
    `CHK({low_power_state_o, clk_src_o, hrdata}, {ST_NORMAL, CLK_MEDIUM_SPEED_INTERNAL_OSC, 32'h0})
    `CHK({cpu_halt_o, osc_stop_o, ctx_valid_o, irq_o}, 4'h2)
    rdc(OFS_STANDBY_CONTROL, 32'h0);
    rdc(OFS_CLK_SEL, 32'h2);
  endtask
  // ==========================================================================
  // Main sequence
  always #2.5 hclk = ~hclk;
  initial begin
    hclk = 1'b0;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    pin_n = 1'b1;
    por = 1'b0;
    lvd = 1'b0;
    err_total = 0;
    compares = 0;
    apage = 24'h0;
    sel_q = 1'b1;
    tr_q = 2'h2;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset();
    t_halt();
    t_cancel();
    t_snooze();
    t_deep();
    t_resets();
    t_bus();
    t_hreset();
    end_of_test();
  end
endmodule // lpmc_top_tb_top
`default_nettype wire
